/* rtl/sfd_map.svh */
// Purpose: Opcodes, field positions and timing counts of the flash decoder.
// Assumes: Included by bare name wherever a constant is needed.
// Notes:   Definitions only.
`ifndef SFD_MAP_SVH
`define SFD_MAP_SVH

// ****************************************************************
// Array geometry
// ****************************************************************
`define SFD_ADDR_W            16
`define SFD_ADDR_TOP          16'hFFFF
`define SFD_ADDR_ONE          16'h0001
`define SFD_SECT_BITS         12
`define SFD_BLOCK_BITS        15

// ****************************************************************
// Instruction opcodes
// ****************************************************************
`define SFD_OP_READ           8'h03
`define SFD_OP_PROG           8'h02
`define SFD_OP_AUTO           8'hAF
`define SFD_OP_SECT           8'h20
`define SFD_OP_BLOCK          8'h52
`define SFD_OP_CHIP           8'h60
`define SFD_OP_STATUS_READ    8'h05
`define SFD_OP_STATUS_ARM     8'h50
`define SFD_OP_STATUS_WRITE   8'h01
`define SFD_OP_WRITE_ENABLE   8'h06
`define SFD_OP_WRITE_DISABLE  8'h04
`define SFD_OP_ID_A           8'h90
`define SFD_OP_ID_B           8'hAB

// ****************************************************************
// Status byte bit positions
// ****************************************************************
`define SFD_ST_BUSY           0
`define SFD_ST_WLATCH         1
`define SFD_ST_BP0            2
`define SFD_ST_BP1            3
`define SFD_ST_AUTO           6
`define SFD_ST_LOCK           7

// ****************************************************************
// Self-timed operation lengths in clock cycles
// ****************************************************************
`define SFD_CNT_W             24
`define SFD_PROG_CYCLES       3500
`define SFD_ERASE_CYCLES      5000
`define SFD_CHIP_CYCLES       9000

`endif

/* rtl/sfd_pkg.sv */
// Purpose: Types shared by the flash instruction decoder.
// Assumes: sfd_map.svh provides the address width.
// Notes:   Used with explicit package scope only.
`include "sfd_map.svh"

package sfd_pkg;

  // ****************************************************************
  // Serial front end states, Gray coded along CMD-ADR-DIN-HOLD.
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_CMD  = 3'h0,
    ST_ADR  = 3'h1,
    ST_DIN  = 3'h3,
    ST_OUT  = 3'h2,
    ST_HOLD = 3'h7
  } sfd_state_type;

  typedef enum logic [2:0] {
    OP_PROG  = 3'h0,
    OP_AUTO  = 3'h1,
    OP_SECT  = 3'h2,
    OP_BLOCK = 3'h3,
    OP_CHIP  = 3'h4
  } sfd_kind_type;

  // One self-timed array operation.
  typedef struct packed {
    sfd_kind_type                kind;
    logic [`SFD_ADDR_W-1:0]      addr;
    logic [7:0]                  data;
  } sfd_op_type;

endpackage

/* rtl/sfd_sync.sv */
// Purpose: Two flip-flop synchroniser for one asynchronous pin.
// Assumes: The pin is a slow level compared with clock_i.
// Notes:   Only the second stage leaves the module.
`timescale 1ns/1ps

module sfd_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock, reset and enable
  input  wire logic clock_i,
  input  wire logic rstn_i,
  input  wire logic ce_i,
  // Pin and synchronised copy
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else if (ce_i) begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;

endmodule // sfd_sync

/* rtl/sfd_decoder.sv */
// Purpose: Instruction interpreter of a small serial flash memory.
// Assumes: SPI mode 0 or 3; serial clock far slower than clock_i.
// Notes:   The array and the protection bits live outside this block.
`timescale 1ns/1ps
`include "sfd_map.svh"

module sfd_decoder #(
  parameter int         PROG_CYCLES  = `SFD_PROG_CYCLES,
  parameter int         ERASE_CYCLES = `SFD_ERASE_CYCLES,
  parameter int         CHIP_CYCLES  = `SFD_CHIP_CYCLES,
  parameter logic [7:0] MANUF_ID     = 8'hC3,  // Arbitrary value.
  parameter logic [7:0] DEVICE_ID    = 8'h3C   // Arbitrary value.
) (
  // Clock, reset and enable
  input  wire logic                   clock_i,
  input  wire logic                   rstn_i,
  input  wire logic                   ce_i,
  // Serial pins
  input  wire logic                   sck_i,
  input  wire logic                   cs_n_i,
  input  wire logic                   si_i,
  output logic                        so_o,
  output logic                        so_oe_o,
  // Array access
  output logic [`SFD_ADDR_W-1:0]      arr_addr_o,
  input  wire logic [7:0]             arr_rdata_i,
  output sfd_pkg::sfd_op_type         arr_op_o,
  output logic                        arr_op_valid_o,
  // Protection and status bits held outside
  input  wire logic [1:0]             bp_i,
  input  wire logic                   lock_i,
  input  wire logic                   prot_on_i,
  input  wire logic [`SFD_ADDR_W-1:0] prot_floor_i,
  output logic                        swr_valid_o,
  output logic [7:0]                  swr_data_o,
  // Status flags
  output logic                        busy_o,
  output logic                        wlatch_o,
  output logic                        auto_o
);

  localparam int AW = `SFD_ADDR_W;
  localparam int CW = `SFD_CNT_W;

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  logic sck_s;
  logic cs_s;
  logic si_s;
  logic sck_d_ff;
  logic cs_d_ff;

  sfd_sync #(.RST_VAL(1'b0)) u_sync_sck (
    .clock_i (clock_i), .rstn_i (rstn_i), .ce_i (ce_i),
    .d_i     (sck_i),   .q_o    (sck_s));
  sfd_sync #(.RST_VAL(1'b1)) u_sync_cs (
    .clock_i (clock_i), .rstn_i (rstn_i), .ce_i (ce_i),
    .d_i     (cs_n_i),  .q_o    (cs_s));
  sfd_sync #(.RST_VAL(1'b0)) u_sync_si (
    .clock_i (clock_i), .rstn_i (rstn_i), .ce_i (ce_i),
    .d_i     (si_i),    .q_o    (si_s));

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sck_d_ff <= 1'b0;
      cs_d_ff  <= 1'b1;
    end else if (ce_i) begin
      sck_d_ff <= sck_s;
      cs_d_ff  <= cs_s;
    end
  end

  wire cs_low   = ~cs_s;
  wire cs_rise  = cs_s & ~cs_d_ff;
  wire sck_rise = sck_s & ~sck_d_ff & cs_low;
  wire sck_fall = ~sck_s & sck_d_ff & cs_low;

  // ****************************************************************
  // Input shifting
  // ****************************************************************
  sfd_pkg::sfd_state_type state_ff;
  sfd_pkg::sfd_state_type nxt_state;
  logic [2:0]    bit_cnt_ff;
  logic [1:0]    byte_cnt_ff;
  logic [7:0]    shin_ff;
  logic [7:0]    cmd_ff;
  logic [AW-1:0] addr_ff;
  logic [7:0]    data_ff;
  logic          pend_ff;
  logic          nxt_pend;

  wire           byte_done = sck_rise & (bit_cnt_ff == 3'h7);
  wire [7:0]     byte_val  = {shin_ff[6:0], si_s};
  wire [AW-1:0]  addr_next = {addr_ff[AW-2:0], si_s};
  wire           in_cmd    = byte_done & (state_ff == sfd_pkg::ST_CMD);
  wire           adr_last  = byte_done & (state_ff == sfd_pkg::ST_ADR) &
                             (byte_cnt_ff == 2'h2);

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bit_cnt_ff  <= 3'h0;
      byte_cnt_ff <= 2'h0;
      shin_ff     <= 8'h00;
    end else if (ce_i) begin
      if (!cs_low) begin
        bit_cnt_ff  <= 3'h0;
        byte_cnt_ff <= 2'h0;
      end else if (sck_rise) begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        shin_ff    <= byte_val;
        if (byte_done && state_ff == sfd_pkg::ST_ADR) begin
          byte_cnt_ff <= byte_cnt_ff + 2'h1;
        end
      end
    end
  end

  // Only the low address bits are kept; upper bits shift out unused.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd_ff  <= 8'h00;
      addr_ff <= '0;
      data_ff <= 8'h00;
    end else if (ce_i) begin
      if (in_cmd) begin
        cmd_ff <= byte_val;
      end
      if (sck_rise && state_ff == sfd_pkg::ST_ADR) begin
        addr_ff <= addr_next;
      end
      if (byte_done && state_ff == sfd_pkg::ST_DIN) begin
        data_ff <= byte_val;
      end
    end
  end

  // ****************************************************************
  // Instruction sequencing
  // ****************************************************************
  logic auto_ff;

  wire cmd_is_out = (cmd_ff == `SFD_OP_READ) || (cmd_ff == `SFD_OP_ID_A) ||
                    (cmd_ff == `SFD_OP_ID_B);
  wire cmd_is_din = (cmd_ff == `SFD_OP_PROG) || (cmd_ff == `SFD_OP_AUTO);

  always_comb begin
    nxt_state = state_ff;
    nxt_pend  = pend_ff;
    if (!cs_low) begin
      nxt_state = sfd_pkg::ST_CMD;
      nxt_pend  = 1'b0;
    end else if (byte_done) begin
      unique case (state_ff)
        sfd_pkg::ST_CMD: begin
          case (byte_val)
            `SFD_OP_READ, `SFD_OP_PROG, `SFD_OP_SECT, `SFD_OP_BLOCK,
            `SFD_OP_ID_A, `SFD_OP_ID_B: nxt_state = sfd_pkg::ST_ADR;
            `SFD_OP_AUTO: nxt_state = auto_ff ? sfd_pkg::ST_DIN
                                              : sfd_pkg::ST_ADR;
            `SFD_OP_STATUS_READ: nxt_state = sfd_pkg::ST_OUT;
            `SFD_OP_STATUS_WRITE: nxt_state = sfd_pkg::ST_DIN;
            `SFD_OP_WRITE_ENABLE, `SFD_OP_WRITE_DISABLE,
            `SFD_OP_STATUS_ARM, `SFD_OP_CHIP: begin
              nxt_state = sfd_pkg::ST_HOLD;
              nxt_pend  = 1'b1;
            end
            default: nxt_state = sfd_pkg::ST_HOLD;
          endcase
        end
        sfd_pkg::ST_ADR: begin
          if (byte_cnt_ff == 2'h2) begin
            if (cmd_is_out) begin
              nxt_state = sfd_pkg::ST_OUT;
            end else if (cmd_is_din) begin
              nxt_state = sfd_pkg::ST_DIN;
            end else begin
              nxt_state = sfd_pkg::ST_HOLD;
              nxt_pend  = 1'b1;
            end
          end
        end
        sfd_pkg::ST_DIN: begin
          nxt_state = sfd_pkg::ST_HOLD;
          nxt_pend  = 1'b1;
        end
        sfd_pkg::ST_OUT, sfd_pkg::ST_HOLD: nxt_state = state_ff;
        default: nxt_state = sfd_pkg::ST_HOLD;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= sfd_pkg::ST_CMD;
      pend_ff  <= 1'b0;
    end else if (ce_i) begin
      state_ff <= nxt_state;
      pend_ff  <= nxt_pend;
    end
  end

  // ****************************************************************
  // Execution at deselect
  // ****************************************************************
  logic          wlatch_ff;
  logic          arm_ff;
  logic          busy_ff;
  logic [CW-1:0] cnt_ff;
  logic [AW-1:0] auto_addr_ff;
  sfd_pkg::sfd_op_type op_ff;
  sfd_pkg::sfd_op_type nxt_op;

  // A partial final byte discards the whole instruction.
  wire exec      = cs_rise & pend_ff & (bit_cnt_ff == 3'h0);
  wire wr_ok     = exec & wlatch_ff & ~busy_ff;
  wire c_prog    = cmd_ff == `SFD_OP_PROG;
  wire c_auto    = cmd_ff == `SFD_OP_AUTO;
  wire c_sect    = cmd_ff == `SFD_OP_SECT;
  wire c_block   = cmd_ff == `SFD_OP_BLOCK;
  wire c_chip    = cmd_ff == `SFD_OP_CHIP;
  wire c_wen     = cmd_ff == `SFD_OP_WRITE_ENABLE;
  wire c_wdis    = cmd_ff == `SFD_OP_WRITE_DISABLE;
  wire c_arm     = cmd_ff == `SFD_OP_STATUS_ARM;
  wire c_swrite  = cmd_ff == `SFD_OP_STATUS_WRITE;

  wire [AW-1:0] auto_tgt  = auto_ff ? auto_addr_ff : addr_ff;
  wire [AW-1:0] sect_end  = {addr_ff[AW-1:`SFD_SECT_BITS],
                             {`SFD_SECT_BITS{1'b1}}};
  wire [AW-1:0] block_end = {addr_ff[AW-1:`SFD_BLOCK_BITS],
                             {`SFD_BLOCK_BITS{1'b1}}};
  wire [AW-1:0] top_free  = prot_on_i ? prot_floor_i - `SFD_ADDR_ONE
                                      : `SFD_ADDR_TOP;
  wire hit_byte  = prot_on_i & (addr_ff >= prot_floor_i);
  wire hit_auto  = prot_on_i & (auto_tgt >= prot_floor_i);
  wire hit_sect  = prot_on_i & (sect_end >= prot_floor_i);
  wire hit_block = prot_on_i & (block_end >= prot_floor_i);

  wire go_prog   = wr_ok & c_prog & ~hit_byte;
  wire go_auto   = wr_ok & c_auto & ~hit_auto;
  wire go_sect   = wr_ok & c_sect & ~hit_sect;
  wire go_block  = wr_ok & c_block & ~hit_block;
  wire go_chip   = wr_ok & c_chip & ~prot_on_i;
  wire op_start  = go_prog | go_auto | go_sect | go_block | go_chip;
  wire auto_last = go_auto & (auto_tgt == top_free);
  wire busy_done = busy_ff & (cnt_ff == {{(CW-1){1'b0}}, 1'b1});
  wire done_clr  = busy_done & (op_ff.kind != sfd_pkg::OP_AUTO);
  wire wdis_exec = exec & c_wdis;

  // A set arriving with a clear wins, except that auto_last clears auto_ff even when go_auto sets it.
  wire nxt_wlatch = (exec & c_wen) |
                    (wlatch_ff & ~wdis_exec & ~done_clr & ~auto_last);
  wire nxt_auto   = (go_auto & ~auto_last) |
                    (auto_ff & ~wdis_exec & ~auto_last);
  wire nxt_arm    = (exec & c_arm) | (arm_ff & ~(exec & c_swrite) &
                    ~(in_cmd & (byte_val != `SFD_OP_STATUS_WRITE)));

  always_comb begin
    nxt_op      = op_ff;
    nxt_op.data = data_ff;
    nxt_op.addr = addr_ff;
    nxt_op.kind = sfd_pkg::OP_PROG;
    if (go_auto) begin
      nxt_op.kind = sfd_pkg::OP_AUTO;
      nxt_op.addr = auto_tgt;
    end else if (go_sect) begin
      nxt_op.kind = sfd_pkg::OP_SECT;
      nxt_op.addr = {addr_ff[AW-1:`SFD_SECT_BITS], {`SFD_SECT_BITS{1'b0}}};
    end else if (go_block) begin
      nxt_op.kind = sfd_pkg::OP_BLOCK;
      nxt_op.addr = {addr_ff[AW-1:`SFD_BLOCK_BITS], {`SFD_BLOCK_BITS{1'b0}}};
    end else if (go_chip) begin
      nxt_op.kind = sfd_pkg::OP_CHIP;
      nxt_op.addr = '0;
    end
  end

  wire [CW-1:0] dur = (go_prog | go_auto) ? CW'(PROG_CYCLES) :
                      go_chip ? CW'(CHIP_CYCLES) : CW'(ERASE_CYCLES);

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wlatch_ff    <= 1'b0;
      auto_ff      <= 1'b0;
      arm_ff       <= 1'b0;
      auto_addr_ff <= '0;
      op_ff        <= '0;
    end else if (ce_i) begin
      wlatch_ff <= nxt_wlatch;
      auto_ff   <= nxt_auto;
      arm_ff    <= nxt_arm;
      if (go_auto) begin
        auto_addr_ff <= auto_tgt + `SFD_ADDR_ONE;
      end
      if (op_start) begin
        op_ff <= nxt_op;
      end
    end
  end

  // Busy counts the self-timed operation down to zero.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_ff        <= 1'b0;
      cnt_ff         <= '0;
      arr_op_valid_o <= 1'b0;
      swr_valid_o    <= 1'b0;
      swr_data_o     <= 8'h00;
    end else if (ce_i) begin
      arr_op_valid_o <= op_start;
      swr_valid_o    <= exec & c_swrite & arm_ff;
      swr_data_o     <= data_ff;
      if (op_start) begin
        busy_ff <= 1'b1;
        cnt_ff  <= dur;
      end else if (busy_ff) begin
        busy_ff <= ~busy_done;
        cnt_ff  <= cnt_ff - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  // ****************************************************************
  // Output stream
  // ****************************************************************
  logic [7:0]    stat_byte;
  logic [7:0]    shout_ff;
  logic [2:0]    obit_ff;
  logic [AW-1:0] rd_addr_ff;

  always_comb begin
    stat_byte                 = 8'h00;
    stat_byte[`SFD_ST_BUSY]   = busy_ff;
    stat_byte[`SFD_ST_WLATCH] = wlatch_ff;
    stat_byte[`SFD_ST_BP0]    = bp_i[0];
    stat_byte[`SFD_ST_BP1]    = bp_i[1];
    stat_byte[`SFD_ST_AUTO]   = auto_ff;
    stat_byte[`SFD_ST_LOCK]   = lock_i;
  end

  wire       is_id    = (cmd_ff == `SFD_OP_ID_A) || (cmd_ff == `SFD_OP_ID_B);
  wire       is_read  = cmd_ff == `SFD_OP_READ;
  wire [7:0] id_byte  = rd_addr_ff[0] ? DEVICE_ID : MANUF_ID;
  wire [7:0] out_byte = is_read ? arr_rdata_i : is_id ? id_byte : stat_byte;
  wire       out_fall = sck_fall & (state_ff == sfd_pkg::ST_OUT);
  wire       out_load = out_fall & (obit_ff == 3'h0);

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      obit_ff    <= 3'h0;
      shout_ff   <= 8'h00;
      so_o       <= 1'b0;
      so_oe_o    <= 1'b0;
      rd_addr_ff <= '0;
    end else if (ce_i) begin
      so_oe_o <= cs_low & (state_ff == sfd_pkg::ST_OUT);
      if (!cs_low) begin
        obit_ff <= 3'h0;
      end else if (out_load) begin
        obit_ff  <= 3'h1;
        so_o     <= out_byte[7];
        shout_ff <= {out_byte[6:0], 1'b0};
      end else if (out_fall) begin
        obit_ff  <= obit_ff + 3'h1;
        so_o     <= shout_ff[7];
        shout_ff <= {shout_ff[6:0], 1'b0};
      end
      if (adr_last) begin
        rd_addr_ff <= addr_next;
      end else if (out_load && is_read) begin
        rd_addr_ff <= rd_addr_ff + `SFD_ADDR_ONE;
      end else if (out_load && is_id) begin
        rd_addr_ff <= rd_addr_ff ^ `SFD_ADDR_ONE;
      end
    end
  end

  assign arr_addr_o = rd_addr_ff;
  assign arr_op_o   = op_ff;
  assign busy_o     = busy_ff;
  assign wlatch_o   = wlatch_ff;
  assign auto_o     = auto_ff;

endmodule // sfd_decoder

/* tb/sfd_decoder_assertions.sv */
// Purpose: Concurrent checks on the ports of the flash decoder.
// Assumes: Bound to every sfd_decoder instance.
// Notes:   Busy length is judged against the kind of the last started op.
`timescale 1ns/1ps
`include "sfd_map.svh"

module sfd_decoder_assertions #(
  parameter int PROG_CYCLES  = `SFD_PROG_CYCLES,
  parameter int ERASE_CYCLES = `SFD_ERASE_CYCLES,
  parameter int CHIP_CYCLES  = `SFD_CHIP_CYCLES
) (
  // Clock, reset and pins
  input  wire logic                   clock_i,
  input  wire logic                   rstn_i,
  input  wire logic                   ce_i,
  input  wire logic                   cs_n_i,
  input  wire logic                   prot_on_i,
  input  wire logic [`SFD_ADDR_W-1:0] prot_floor_i,
  // Outputs watched
  input  wire logic                   so_oe_o,
  input  wire sfd_pkg::sfd_op_type    arr_op_o,
  input  wire logic                   arr_op_valid_o,
  input  wire logic                   busy_o,
  input  wire logic                   wlatch_o
);
  // ********
  // Busy cycle counter
  // ********
  logic [`SFD_CNT_W-1:0] busy_cnt_ff;
  logic [`SFD_CNT_W-1:0] nxt_busy_cnt;
  int                    want_cnt;
  logic                  is_prog;
  assign is_prog = arr_op_o.kind inside {sfd_pkg::OP_PROG, sfd_pkg::OP_AUTO};
  assign want_cnt = is_prog ? PROG_CYCLES :
                    (arr_op_o.kind == sfd_pkg::OP_CHIP) ? CHIP_CYCLES :
                    ERASE_CYCLES;
  assign nxt_busy_cnt = busy_o ? busy_cnt_ff + `SFD_CNT_W'(1) : '0;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) busy_cnt_ff <= '0;
    else if (ce_i) busy_cnt_ff <= nxt_busy_cnt;
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  busy_start_a: assert property ($rose(busy_o) |-> arr_op_valid_o)
    else $error("busy rose without an op start");
  busy_len_a: assert property (
    $fell(busy_o) |-> busy_cnt_ff == `SFD_CNT_W'(want_cnt))
    else $error("busy length differs from the op length");
  op_pulse_a: assert property (
    arr_op_valid_o |-> busy_o ##1 !arr_op_valid_o)
    else $error("op start is not a single pulse with busy");
  op_idle_a: assert property (arr_op_valid_o |-> !$past(busy_o))
    else $error("op started while busy");
  op_latch_a: assert property (arr_op_valid_o |-> $past(wlatch_o))
    else $error("op started without the write latch");
  chip_prot_a: assert property (
    arr_op_valid_o && arr_op_o.kind == sfd_pkg::OP_CHIP |-> !prot_on_i)
    else $error("chip erase started while protected");
  prog_prot_a: assert property (
    arr_op_valid_o && is_prog && prot_on_i |-> arr_op_o.addr < prot_floor_i)
    else $error("program started in the protected region");
  oe_idle_a: assert property (cs_n_i [*6] |-> !so_oe_o)
    else $error("output driven while deselected");
  done_latch_a: assert property (
    $fell(busy_o) && arr_op_o.kind != sfd_pkg::OP_AUTO |-> !wlatch_o)
    else $error("latch kept after a byte program or erase");
endmodule // sfd_decoder_assertions

bind sfd_decoder sfd_decoder_assertions #(
  .PROG_CYCLES (PROG_CYCLES),
  .ERASE_CYCLES(ERASE_CYCLES),
  .CHIP_CYCLES (CHIP_CYCLES)
) i_chk (
  .clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce_i), .cs_n_i(cs_n_i),
  .prot_on_i(prot_on_i), .prot_floor_i(prot_floor_i),
  .so_oe_o(so_oe_o), .arr_op_o(arr_op_o),
  .arr_op_valid_o(arr_op_valid_o), .busy_o(busy_o), .wlatch_o(wlatch_o)
);

/* tb/sfd_host.sv */
// Purpose: Host SPI controller model, mode 0, 80 ns serial clock.
// Assumes: Tasks are called from the bench top.
// Notes:   Data line is flipped between frames so no stale value lingers.
`timescale 1ns/1ps

module sfd_host (
  // Clock and device output
  input  wire logic clock_i,
  input  wire logic so_i,
  input  wire logic so_oe_i,
  // Serial pins toward the device
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      si_o
);
  initial begin
    sck_o  = 1'b0;
    cs_n_o = 1'b1;
    si_o   = 1'b0;
  end

  // ********
  // One framed transfer
  // ********
  task automatic frame(input logic [63:0] d, input int n,
                       output logic [63:0] q);
    q = '0;
    @(posedge clock_i);
    #1 cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si_o = d[i];
      #40 sck_o = 1'b1;
      q = {q[62:0], so_oe_i ? so_i : 1'b0};
      #40 sck_o = 1'b0;
    end
    #40 cs_n_o = 1'b1;
    si_o = ~si_o;
    #40;
  endtask
endmodule // sfd_host

/* tb/sfd_decoder_tb_top.sv */
// Purpose: Self-checking bench of the flash instruction decoder.
// Assumes: Short self-timed counts keep the run brief.
// Notes:   The array is a fixed function of the read address.
`timescale 1ns/1ps
`include "sfd_map.svh"

module sfd_decoder_tb_top;
  localparam int         PC  = 400;
  localparam int         EC  = 300;
  localparam int         CC  = 350;
  localparam logic [7:0] MID = 8'h1D;  // Arbitrary value.
  localparam logic [7:0] DID = 8'hE2;  // Arbitrary value.
  logic clock_i, rstn_i, sck, cs_n, si, so, so_oe, prot_on, lock;
  logic busy, wlatch, auto_f, swr_valid, op_valid;
  logic [1:0]             bp;
  logic [7:0]             rdata, swr_data;
  logic [`SFD_ADDR_W-1:0] arr_addr, floor_a;
  sfd_pkg::sfd_op_type    arr_op;
  logic [63:0]            q;
  int n_fail = 0, samples_checked = 0, n_ops = 0, n_swr = 0;

  function automatic logic [7:0] mem(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  assign rdata = mem(arr_addr);

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    if (op_valid === 1'b1) n_ops++;
    if (swr_valid === 1'b1) n_swr++;
  end

  sfd_host i_host (.clock_i(clock_i), .so_i(so), .so_oe_i(so_oe),
    .sck_o(sck), .cs_n_o(cs_n), .si_o(si));
  sfd_decoder #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC), .CHIP_CYCLES(CC),
    .MANUF_ID(MID), .DEVICE_ID(DID)) i_dut (
    .clock_i(clock_i), .rstn_i(rstn_i), .ce_i(1'b1), .sck_i(sck),
    .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe),
    .arr_addr_o(arr_addr), .arr_rdata_i(rdata), .arr_op_o(arr_op),
    .arr_op_valid_o(op_valid), .bp_i(bp), .lock_i(lock),
    .prot_on_i(prot_on), .prot_floor_i(floor_a),
    .swr_valid_o(swr_valid), .swr_data_o(swr_data), .busy_o(busy),
    .wlatch_o(wlatch), .auto_o(auto_f));

  // ********
  // Tasks
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    i_host.frame({56'h0, op}, 8, q);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 600 && busy !== 1'b0; i++) begin
      @(posedge clock_i);
      #1;
    end
    chk(busy, 1'b0);
  endtask
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask
  task automatic end_sim();
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    end_sim();
  end

  // ********
  // Tests
  // ********
  initial begin
    rstn_i = 1'b0; bp = 2'h2; lock = 1'b1; prot_on = 1'b0;
    floor_a = 16'h8000;
    repeat (4) @(posedge clock_i);
    #1 rstn_i = 1'b1;
    repeat (3) @(posedge clock_i);
    i_host.frame({40'h0, 8'h05, 16'h0}, 24, q);
    chk(q[15:0], 16'h8888);
    i_host.frame({8'h0, 8'h03, 24'hA5FFFE, 24'h0}, 56, q);
    chk(q[23:0], {mem(16'hFFFE), mem(16'hFFFF), mem(16'h0000)});
    tdone("read");
    i_host.frame(64'h03, 7, q);
    chk(wlatch, 1'b0);
    i_host.frame(64'h00C, 9, q);
    chk(wlatch, 1'b0);
    i_host.frame({24'h0, 8'h02, 24'h001234, 8'h5A}, 40, q);
    chk(n_ops, 0);
    cmd(8'h06);
    chk(wlatch, 1'b1);
    i_host.frame({24'h0, 8'h02, 24'h001234, 8'h5A}, 40, q);
    chk({n_ops[3:0], arr_op}, {4'h1, sfd_pkg::OP_PROG, 24'h12345A});
    i_host.frame({48'h0, 8'h05, 8'h0}, 16, q);
    chk(q[7:0], 8'h8B);
    wait_idle();
    chk(wlatch, 1'b0);
    tdone("program");
    prot_on = 1'b1;
    cmd(8'h06);
    i_host.frame({32'h0, 8'h20, 24'h009ABC}, 32, q);
    chk(n_ops, 1);
    i_host.frame({32'h0, 8'h20, 24'h001ABC}, 32, q);
    chk({arr_op.kind, arr_op.addr[15:12]}, {sfd_pkg::OP_SECT, 4'h1});
    wait_idle();
    cmd(8'h06);
    i_host.frame({32'h0, 8'h52, 24'hFF4321}, 32, q);
    chk({arr_op.kind, arr_op.addr[15]}, {sfd_pkg::OP_BLOCK, 1'b0});
    wait_idle();
    cmd(8'h06);
    cmd(8'h60);
    chk(n_ops, 3);
    prot_on = 1'b0;
    cmd(8'h60);
    chk({n_ops[3:0], arr_op.kind}, {4'h4, sfd_pkg::OP_CHIP});
    wait_idle();
    tdone("erase");
    prot_on = 1'b1;
    cmd(8'h06);
    i_host.frame({24'h0, 8'hAF, 24'h007FFE, 8'h11}, 40, q);
    chk(auto_f, 1'b1);
    wait_idle();
    i_host.frame({48'h0, 8'hAF, 8'h22}, 16, q);
    chk(arr_op, {sfd_pkg::OP_AUTO, 24'h7FFF22});
    chk({auto_f, wlatch}, 2'h0);
    wait_idle();
    cmd(8'h06);
    i_host.frame({24'h0, 8'hAF, 24'h000100, 8'h33}, 40, q);
    wait_idle();
    chk(auto_f, 1'b1);
    cmd(8'h04);
    chk({auto_f, wlatch}, 2'h0);
    tdone("auto");
    cmd(8'h50);
    i_host.frame({48'h0, 8'h01, 8'h0C}, 16, q);
    chk({n_swr[3:0], swr_data}, 12'h10C);
    i_host.frame({48'h0, 8'h01, 8'h0C}, 16, q);
    cmd(8'h50);
    cmd(8'h06);
    i_host.frame({48'h0, 8'h01, 8'h0C}, 16, q);
    chk(n_swr, 1);
    tdone("status write");
    i_host.frame({16'h0, 8'h90, 24'h000001, 16'h0}, 48, q);
    chk(q[15:0], {DID, MID});
    i_host.frame({16'h0, 8'hAB, 24'h000000, 16'h0}, 48, q);
    chk(q[15:0], {MID, DID});
    tdone("identification");
    end_sim();
  end
endmodule // sfd_decoder_tb_top
